// ==== hdl/ext_bus_pkg.sv ====
/*
 * Package for the expansion bus controller: register map, field layout,
 * reset values, mode and access-type encodings, bus carrier structs.
 * Assumes nothing of its surroundings.
 */
package ext_bus_pkg;

    // Register indices on the Avalon side (byte address = 4 * index)
    localparam logic [7:0] REG_PORT_A_DATA = 8'h00;
    localparam logic [7:0] REG_PORT_A_DIRECTION = 8'h02;
    localparam logic [7:0] REG_PORT_E_DATA = 8'h08;
    localparam logic [7:0] REG_PORT_E_DIRECTION = 8'h09;
    localparam logic [7:0] REG_MAPPING_EXTRAS = 8'h13;
    localparam logic [7:0] REG_BUS_MODE = 8'h20;
    localparam logic [7:0] REG_ACCESS_CTRL = 8'h21;
    localparam logic [7:0] REG_ACCESS_ADDR = 8'h22;
    localparam logic [7:0] REG_ACCESS_DATA = 8'h23;
    localparam logic [7:0] REG_ACCESS_STATUS = 8'h24;
    localparam logic [7:0] REG_REG_BASE = 8'h25;

    // Mapping extras control fields
    localparam int NARROW_FOLLOW_POS = 6;
    localparam int FOLLOW_STRETCH_POS = 4;
    localparam int EXTERNAL_STRETCH_POS = 2;
    localparam int FLASH_SMALL_POS = 1;
    localparam int FLASH_LARGE_POS = 0;
    localparam logic [7:0] MAPPING_RESET_EXP = 8'h0C;
    localparam logic [7:0] MAPPING_RESET_SC = 8'h0F;

    // Bus mode register fields
    localparam int EMULATE_E_POS = 2;
    localparam logic [7:0] BUS_MODE_RESET = 8'h00;

    // Access control fields
    localparam int ACC_WRITE_POS = 0;
    localparam int ACC_WIDE_POS = 1;

    // Address map
    localparam logic [15:0] FOLLOW_OFFSET = 16'h0200;
    localparam logic [15:0] FLASH_SMALL_LO = 16'h1000;
    localparam logic [15:0] FLASH_LARGE_LO = 16'h8000;
    localparam logic [15:0] REG_BASE_RESET = 16'h0000;
    localparam logic [15:0] PORT_REG_COUNT = 16'h0010;
    localparam logic [15:0] RAM_BASE_RESET = 16'h0000;
    localparam logic [15:0] RAM_SIZE = 16'h0800;

    // Timing: one E clock is this many system clocks
    localparam int E_CLOCK_DIV = 4;

    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_EXPANDED_NARROW,
        MODE_EXPANDED_WIDE,
        MODE_PERIPHERAL
    } chip_mode_t;

    typedef enum logic [1:0] {
        TARGET_INTERNAL_REG,
        TARGET_INTERNAL_MEM,
        TARGET_EXTERNAL
    } target_t;

    // External bus control pins as a group
    typedef struct packed {
        logic low_byte_strobe;
        logic addr0;
        logic read_not_write;
    } bus_ctrl_t;

    // One access request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic wide;
    } access_req_t;

endpackage

// ==== hdl/e_clock_divider.sv ====
/*
 * Divider giving the E-clock period enable and the phase level.
 * Assumes one system clock; enable is a single-cycle pulse.
 */
`timescale 1ns/1ps
module e_clock_divider #(
    parameter int DIV = ext_bus_pkg::E_CLOCK_DIV
) (
    input wire logic clk,
    input wire logic nrst,
    output logic e_tick,
    output logic e_high
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] count;

    initial begin
        if (DIV < 2 || (DIV % 2) != 0) begin
            $error("DIV must be even and at least 2");
        end
    end

    wire at_end = (count == CW'(DIV - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            e_tick <= 1'b0;
            e_high <= 1'b0;
        end else begin
            count <= at_end ? '0 : count + 1'b1;
            e_tick <= at_end;
            e_high <= (count >= CW'(DIV / 2 - 1)) && !at_end;
        end
    end
endmodule // e_clock_divider

// ==== hdl/ext_bus_ctrl.sv ====
/*
 * Expansion bus controller: stretch timing, flash map gates, access-type
 * encoding, port map removal, port A address/data/GPIO mux, Avalon slave.
 * Assumes mode straps stable at reset release and a pin pad that resolves
 * port_a_pins from out/oe (oe low drives).
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
// Overview of operation
// [RULE_01] Follow space stretched 0..3 E clocks
// [RULE_02] Follow stretch applies narrow or wide
// [RULE_03] External space stretched 0..3 E clocks
// [RULE_04] Flash enable bits gate arrays in map
// [RULE_05] Internal 16-bit path drives 8/16 bus
// [RULE_06] Narrow follow bit mixes 8/16 peripherals
// [RULE_07] Byte access strobe and A0 encoding
// [RULE_08] Even word access strobe and A0 low
// [RULE_09] Strobe and A0 high only internal RAM
// [RULE_10] Misaligned word swaps data bytes
// [RULE_11] Peripheral mode removes first 16 registers
// [RULE_12] Expanded modes move port A/B externally
// [RULE_13] Emulate bit moves port E externally
// [RULE_14] Port A multiplexes high address/data
// [RULE_15] Port A GPIO when not addressing
// [RULE_16] Direction bit 0 input, 1 output
// [RULE_17] Narrow follow uses 8-bit port A path
// [RULE_18] Follow space tracks register block base
// [RULE_19] Stretch holds address and controls stable
`timescale 1ns/1ps
module ext_bus_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] mode_strap,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe_n,
    input wire logic [7:0] port_b_pins_in,
    output logic [7:0] port_b_pins_out,
    output logic [7:0] port_b_pins_oe_n,
    output ext_bus_pkg::bus_ctrl_t bus_ctrl,
    output logic e_clock,
    output logic flash_small_array_sel,
    output logic flash_large_array_sel
);

////////////////////////////////////////////////////////////////////////////////

    logic [1:0] strap_meta, strap_sync;
    logic [1:0] settle;
    ext_bus_pkg::chip_mode_t mode;
    logic mode_valid;
    logic [7:0] port_a_data, port_a_direction, port_e_data, port_e_direction;
    logic [7:0] mapping_extras_control, bus_mode_reg;
    logic [4:0] reg_base_hi;
    ext_bus_pkg::access_req_t req;
    logic [15:0] rd_data;
    logic acc_busy, acc_done;
    logic [31:0] next_readdata;
    logic e_tick, e_high;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
        end else begin
            strap_meta <= mode_strap;
            strap_sync <= strap_meta;
        end
    end

    // Mode latched once the synchroniser holds real strap levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode <= ext_bus_pkg::MODE_SINGLE_CHIP;
            mode_valid <= 1'b0;
            settle <= 2'h0;
        end else if (!mode_valid) begin
            if (settle != 2'h2) begin
                settle <= settle + 2'h1;
            end else begin
                mode <= ext_bus_pkg::chip_mode_t'(strap_sync);
                mode_valid <= 1'b1;
            end
        end
    end

    e_clock_divider #(.DIV(ext_bus_pkg::E_CLOCK_DIV)) u_div (
        .clk(clk),
        .nrst(nrst),
        .e_tick(e_tick),
        .e_high(e_high)
    );

////////////////////////////////////////////////////////////////////////////////
// Mode decode

    wire expanded = (mode == ext_bus_pkg::MODE_EXPANDED_NARROW) ||
        (mode == ext_bus_pkg::MODE_EXPANDED_WIDE);
    wire peripheral = (mode == ext_bus_pkg::MODE_PERIPHERAL);
    wire emulate_e_port_regs = bus_mode_reg[ext_bus_pkg::EMULATE_E_POS];
    wire narrow_follow_space =
        mapping_extras_control[ext_bus_pkg::NARROW_FOLLOW_POS];
    wire [1:0] follow_space_stretch =
        mapping_extras_control[ext_bus_pkg::FOLLOW_STRETCH_POS +: 2];
    wire [1:0] external_space_stretch =
        mapping_extras_control[ext_bus_pkg::EXTERNAL_STRETCH_POS +: 2];
    wire flash_small_array_enable =
        mapping_extras_control[ext_bus_pkg::FLASH_SMALL_POS];
    wire flash_large_array_enable =
        mapping_extras_control[ext_bus_pkg::FLASH_LARGE_POS];
    wire [15:0] reg_base = {reg_base_hi, 11'h000};

    // Port registers present on chip for this mode
    function automatic logic port_reg_present(input logic [7:0] idx);
        logic ab, e;
        ab = (idx < 8'h04);
        e = (idx == 8'h08) || (idx == 8'h09);
        if (peripheral && idx < 8'(ext_bus_pkg::PORT_REG_COUNT))
            return 1'b0; // RULE_11
        if (expanded && ab)
            return 1'b0; // RULE_12
        if (expanded && emulate_e_port_regs && e)
            return 1'b0; // RULE_13
        return 1'b1;
    endfunction

    function automatic ext_bus_pkg::target_t classify(input logic [15:0] a);
        logic [15:0] off;
        off = a - reg_base;
        if (off < ext_bus_pkg::FOLLOW_OFFSET && port_reg_present(off[7:0]))
            return ext_bus_pkg::TARGET_INTERNAL_REG;
        if ((a - ext_bus_pkg::RAM_BASE_RESET) < ext_bus_pkg::RAM_SIZE)
            return ext_bus_pkg::TARGET_INTERNAL_MEM;
        if (flash_small_array_enable && a >= ext_bus_pkg::FLASH_SMALL_LO &&
            a < ext_bus_pkg::FLASH_LARGE_LO)
            return ext_bus_pkg::TARGET_INTERNAL_MEM; // RULE_04
        if (flash_large_array_enable && a >= ext_bus_pkg::FLASH_LARGE_LO)
            return ext_bus_pkg::TARGET_INTERNAL_MEM; // RULE_04
        return ext_bus_pkg::TARGET_EXTERNAL;
    endfunction

    wire ext_mode = expanded;
    wire [15:0] req_off = req.addr - reg_base;
    // Follow space sits right behind the register block
    wire in_follow = (req_off >= ext_bus_pkg::FOLLOW_OFFSET) &&
        (req_off < (ext_bus_pkg::FOLLOW_OFFSET << 1)); // RULE_18
    wire is_internal_ram = (req.addr - ext_bus_pkg::RAM_BASE_RESET) <
        ext_bus_pkg::RAM_SIZE;
    wire [1:0] stretch = !ext_mode ? 2'h0 :
        in_follow ? follow_space_stretch : // RULE_01 RULE_02
        external_space_stretch; // RULE_03
    wire narrow_access = (mode == ext_bus_pkg::MODE_EXPANDED_NARROW) ||
        (in_follow && narrow_follow_space &&
        mode == ext_bus_pkg::MODE_EXPANDED_WIDE); // RULE_06 RULE_17
    assign flash_small_array_sel = flash_small_array_enable;
    assign flash_large_array_sel = flash_large_array_enable;

////////////////////////////////////////////////////////////////////////////////
// External access sequencer

    typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_STRETCH} seq_state_t;
    seq_state_t state;
    logic [1:0] stretch_left;
    wire misaligned = req.wide && req.addr[0];
    // Misaligned word only legal toward internal RAM
    wire wide_ok = !misaligned || is_internal_ram; // RULE_09
    wire [15:0] wdata_bus = misaligned ?
        {req.wdata[7:0], req.wdata[15:8]} : req.wdata; // RULE_10
    logic start;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
            stretch_left <= 2'h0;
            acc_done <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            acc_done <= 1'b0;
            unique case (state)
                S_IDLE: if (start) state <= S_ADDR;
                S_ADDR: if (e_tick) begin
                    state <= S_DATA;
                    stretch_left <= stretch;
                end
                S_DATA, S_STRETCH: if (e_tick) begin
                    if (stretch_left != 2'h0) begin
                        state <= S_STRETCH; // RULE_19
                        stretch_left <= stretch_left - 2'h1;
                    end else begin
                        state <= S_IDLE;
                        acc_done <= 1'b1;
                        rd_data <= narrow_access ?
                            {8'h00, port_a_pins_in} :
                            misaligned ?
                            {port_b_pins_in, port_a_pins_in} : // RULE_10
                            {port_a_pins_in, port_b_pins_in}; // RULE_05
                    end
                end
            endcase
        end
    end

    wire data_phase = (state == S_DATA) || (state == S_STRETCH);
    wire active = state != S_IDLE;

    // Access type pins; held for the whole access
    wire next_strobe = req.wide ? req.addr[0] : req.addr[0] ^ 1'b1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_ctrl <= '{low_byte_strobe: 1'b1, addr0: 1'b0,
                read_not_write: 1'b1};
        end else if (active) begin
            bus_ctrl.low_byte_strobe <= next_strobe; // RULE_07 RULE_08
            bus_ctrl.addr0 <= req.addr[0]; // RULE_07 RULE_08
            bus_ctrl.read_not_write <= !req.write;
        end else begin
            bus_ctrl.read_not_write <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Port A and B pin mux

    wire [7:0] a_addr_out = req.addr[15:8]; // RULE_14
    wire [7:0] a_data_out = narrow_access ?
        (req.addr[0] ? wdata_bus[7:0] : wdata_bus[15:8]) :
        wdata_bus[15:8]; // RULE_14 RULE_17
    wire drive_data = data_phase && req.write;
    wire [7:0] next_a_out = !ext_mode ? port_a_data : // RULE_15
        data_phase ? a_data_out : a_addr_out;
    wire [7:0] next_a_oe_n = !ext_mode ? ~port_a_direction : // RULE_16
        (!active || (!data_phase) || drive_data) ? 8'h00 : 8'hFF;
    wire [7:0] next_b_out = !ext_mode ? 8'h00 :
        data_phase ? wdata_bus[7:0] : req.addr[7:0];
    wire [7:0] next_b_oe_n = !ext_mode ? 8'hFF :
        (data_phase && (!req.write || narrow_access)) ? 8'hFF : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_pins_out <= 8'h00;
            port_a_pins_oe_n <= 8'hFF;
            port_b_pins_out <= 8'h00;
            port_b_pins_oe_n <= 8'hFF;
            e_clock <= 1'b0;
        end else begin
            port_a_pins_out <= next_a_out;
            port_a_pins_oe_n <= next_a_oe_n;
            port_b_pins_out <= next_b_out;
            port_b_pins_oe_n <= next_b_oe_n;
            e_clock <= e_high;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave

    wire acc_cmd = avs_write && avs_address == ext_bus_pkg::REG_ACCESS_CTRL;
    wire a_reg_vis = port_reg_present(ext_bus_pkg::REG_PORT_A_DATA);
    wire e_reg_vis = port_reg_present(ext_bus_pkg::REG_PORT_E_DATA); // RULE_13
    assign start = acc_cmd && !acc_busy && ext_mode &&
        classify(avs_writedata[31:16]) == ext_bus_pkg::TARGET_EXTERNAL &&
        (!(avs_writedata[ext_bus_pkg::ACC_WIDE_POS] && avs_writedata[16]));
    logic done_seen;

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            ext_bus_pkg::REG_PORT_A_DATA:
                next_readdata[7:0] = a_reg_vis ? port_a_data : 8'h00;
            ext_bus_pkg::REG_PORT_A_DIRECTION:
                next_readdata[7:0] = a_reg_vis ? port_a_direction : 8'h00;
            ext_bus_pkg::REG_PORT_E_DATA:
                next_readdata[7:0] = e_reg_vis ? port_e_data : 8'h00;
            ext_bus_pkg::REG_PORT_E_DIRECTION:
                next_readdata[7:0] = e_reg_vis ? port_e_direction : 8'h00;
            ext_bus_pkg::REG_MAPPING_EXTRAS:
                next_readdata[7:0] = mapping_extras_control;
            ext_bus_pkg::REG_BUS_MODE:
                next_readdata[7:0] = {bus_mode_reg[7:3], bus_mode_reg[2],
                    mode};
            ext_bus_pkg::REG_ACCESS_ADDR: next_readdata = {req.addr, 16'h0000};
            ext_bus_pkg::REG_ACCESS_DATA: next_readdata[15:0] = rd_data;
            ext_bus_pkg::REG_ACCESS_STATUS:
                next_readdata[1:0] = {wide_ok, acc_busy};
            ext_bus_pkg::REG_REG_BASE: next_readdata[4:0] = reg_base_hi;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // A write to REG_ACCESS_CTRL stalls while an external access runs
    wire wr_go = avs_write && avs_waitrequest && !(acc_cmd && acc_busy);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            done_seen <= 1'b0;
        end else begin
            avs_waitrequest <= !((avs_read || wr_go) && avs_waitrequest);
            if (avs_read && avs_waitrequest) avs_readdata <= next_readdata;
        end
    end

    wire wr_take = avs_write && !avs_waitrequest;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_data <= 8'h00;
            port_a_direction <= 8'h00;
            port_e_data <= 8'h00;
            port_e_direction <= 8'h00;
            mapping_extras_control <= ext_bus_pkg::MAPPING_RESET_SC;
            bus_mode_reg <= ext_bus_pkg::BUS_MODE_RESET;
            reg_base_hi <= ext_bus_pkg::REG_BASE_RESET[15:11];
            req <= '0;
            acc_busy <= 1'b0;
        end else begin
            if (!mode_valid && settle == 2'h2 &&
                (strap_sync == 2'h1 || strap_sync == 2'h2))
                mapping_extras_control <= ext_bus_pkg::MAPPING_RESET_EXP;
            if (acc_done) acc_busy <= 1'b0;
            if (start) acc_busy <= 1'b1;
            if (wr_take) begin
                unique case (avs_address)
                    ext_bus_pkg::REG_PORT_A_DATA:
                        if (a_reg_vis) port_a_data <= avs_writedata[7:0];
                    ext_bus_pkg::REG_PORT_A_DIRECTION:
                        if (a_reg_vis) port_a_direction <= avs_writedata[7:0];
                    ext_bus_pkg::REG_PORT_E_DATA:
                        if (e_reg_vis) port_e_data <= avs_writedata[7:0];
                    ext_bus_pkg::REG_PORT_E_DIRECTION:
                        if (e_reg_vis) port_e_direction <= avs_writedata[7:0];
                    ext_bus_pkg::REG_MAPPING_EXTRAS:
                        mapping_extras_control <= avs_writedata[7:0];
                    ext_bus_pkg::REG_BUS_MODE: bus_mode_reg <= avs_writedata[7:0];
                    ext_bus_pkg::REG_REG_BASE: reg_base_hi <= avs_writedata[4:0];
                    default: ;
                endcase
            end
            if (start) begin
                req.addr <= avs_writedata[31:16];
                // Byte goes on both halves; word data kept from ACCESS_DATA
                if (!avs_writedata[ext_bus_pkg::ACC_WIDE_POS])
                    req.wdata <= {avs_writedata[15:8], avs_writedata[15:8]};
                req.write <= avs_writedata[ext_bus_pkg::ACC_WRITE_POS];
                req.wide <= avs_writedata[ext_bus_pkg::ACC_WIDE_POS];
            end else if (wr_take && avs_address == ext_bus_pkg::REG_ACCESS_DATA)
                req.wdata <= avs_writedata[15:0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Checks

    sequence s_start;
        state == S_IDLE && start;
    endsequence

    AST_STRETCH_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        (state == S_ADDR && e_tick && stretch == 2'h0) |=>
        state == S_DATA) else $error("Data phase not entered"); // RULE_01
    AST_STRETCH_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        (state == S_DATA && e_tick && stretch_left != 2'h0) |=>
        state == S_STRETCH) else $error("Stretch skipped"); // RULE_03
    AST_HOLD_ADDR: assert property (@(posedge clk) disable iff (!nrst)
        (data_phase && !e_tick) |=> $stable(req.addr))
        else $error("Address moved in access"); // RULE_19
    AST_START_ADDR: assert property (@(posedge clk) disable iff (!nrst)
        s_start |=> state == S_ADDR) else $error("Start lost"); // RULE_05
    AST_STROBE_WORD: assert property (@(posedge clk) disable iff (!nrst)
        (active && req.wide && !req.addr[0]) |=>
        !bus_ctrl.low_byte_strobe) else $error("Word strobe high"); // RULE_08
    AST_STROBE_BYTE: assert property (@(posedge clk) disable iff (!nrst)
        (active && !req.wide) |=>
        bus_ctrl.low_byte_strobe != bus_ctrl.addr0)
        else $error("Byte strobe wrong"); // RULE_07
    AST_GPIO_DIR: assert property (@(posedge clk) disable iff (!nrst)
        (mode_valid && !ext_mode) |=>
        port_a_pins_oe_n == ~$past(port_a_direction))
        else $error("GPIO direction wrong"); // RULE_16
    AST_NO_STRETCH_SC: assert property (@(posedge clk) disable iff (!nrst)
        !ext_mode |-> stretch == 2'h0) else $error("Stretch in SC"); // RULE_01

endmodule // ext_bus_ctrl

// ==== verif/ext_mem_model.sv ====
/*
 * Far-side model: pin echo, toggling released lines and size decode on the multiplexed
 * bus. Assumes oe_n low means the controller drives the pin.
 */
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic clk,
    input wire ext_bus_pkg::bus_ctrl_t ctrl,
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe_n,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe_n,
    output logic [7:0] a_in,
    output logic [7:0] b_in,
    output logic word_cycle
);
    logic [7:0] pat = 8'h5A;
    // No pull-ups: released lines toggle so stale data never matches
    always @(posedge clk) pat <= ~pat;
    assign a_in = (a_out & ~a_oe_n) | (pat & a_oe_n);
    assign b_in = (b_out & ~b_oe_n) | (~pat & b_oe_n);
    // Size decode as external glue logic would do it
    assign word_cycle = ~ctrl.low_byte_strobe & ~ctrl.addr0;
endmodule // ext_mem_model

// ==== verif/ext_bus_ctrl_test.sv ====
/*
 * Self-checking bench: mapping resets, flash gates, port A map and GPIO,
 * external access encoding and stretch. Needs ext_mem_model.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module ext_bus_ctrl_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode_strap = 2'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
    ext_bus_pkg::bus_ctrl_t bus_ctrl;
    logic e_clock, fs_sel, fl_sel, word_cycle;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            failures++;
            results();
        end
    end
    ext_bus_ctrl u_ext_bus_ctrl (.clk(clk), .nrst(nrst),
        .mode_strap(mode_strap), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_a_pins_in(a_in),
        .port_a_pins_out(a_out), .port_a_pins_oe_n(a_oe_n),
        .port_b_pins_in(b_in), .port_b_pins_out(b_out),
        .port_b_pins_oe_n(b_oe_n), .bus_ctrl(bus_ctrl), .e_clock(e_clock),
        .flash_small_array_sel(fs_sel), .flash_large_array_sel(fl_sel));
    ext_mem_model u_ext_mem_model (.clk(clk), .ctrl(bus_ctrl),
        .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
        .a_in(a_in), .b_in(b_in), .word_cycle(word_cycle));
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40) begin
            failures++;
            results();
        end
        // Gap edge so strobes never change twice in one step
        @(posedge clk);
    endtask
    task automatic rst(input logic [1:0] m);
        nrst <= 1'b0;
        mode_strap <= m;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    function automatic ext_bus_pkg::bus_ctrl_t exp_ctrl(input logic a0,
        input logic wide, input logic w);
        exp_ctrl = {~wide & ~a0, a0, ~w};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [7:0] r, v, mp;
        logic [15:0] ad;
        logic wd, wr;
        int t0, d;
        int tm[8];
        ext_bus_pkg::bus_ctrl_t ct;
        q = $urandom(32'h6b9b15c6);
        for (int m = 0; m < 4; m++) begin
            rst(m[1:0]);
            mp = (m == 1 || m == 2) ? ext_bus_pkg::MAPPING_RESET_EXP
                : ext_bus_pkg::MAPPING_RESET_SC;
            bus(1'b0, ext_bus_pkg::REG_MAPPING_EXTRAS, 32'h0, q);
            `CHK(q[7:0], mp)
            `CHK({fs_sel, fl_sel}, mp[1:0])
            r = $urandom;
            v = $urandom;
            bus(1'b1, ext_bus_pkg::REG_PORT_A_DIRECTION, {24'h0, r}, q);
            bus(1'b0, ext_bus_pkg::REG_PORT_A_DIRECTION, 32'h0, q);
            `CHK(q[7:0], (m == 0) ? r : 8'h00)
            if (m == 0) begin
                bus(1'b1, ext_bus_pkg::REG_PORT_A_DATA, {24'h0, v}, q);
                repeat (2) @(posedge clk);
                `CHK(a_oe_n, ~r)
                `CHK(a_out & r, v & r)
                bus(1'b0, 8'h7F, 32'h0, q);
                `CHK(q, 32'h0)
                for (int k = 0; k < 4; k++) begin
                    bus(1'b1, ext_bus_pkg::REG_MAPPING_EXTRAS, k, q);
                    @(posedge clk);
                    `CHK({fs_sel, fl_sel}, k[1:0])
                end
            end
            if (m == 2) begin
                // Block to 0x4000 so its follow space clears internal RAM
                bus(1'b1, ext_bus_pkg::REG_REG_BASE, 32'h8, q);
                for (int k = 0; k < 8; k++) begin
                    r = $urandom;
                    wr = $urandom;
                    mp = k[2] ? {1'b0, r[0], k[1:0], 4'h0}
                        : {4'h0, k[1:0], 2'h0};
                    ad = (k[2] ? 16'h4200 : 16'h6000) + {8'h0, r};
                    wd = ~r[0] & ~k[2];
                    bus(1'b1, ext_bus_pkg::REG_MAPPING_EXTRAS, mp, q);
                    bus(1'b1, ext_bus_pkg::REG_ACCESS_CTRL,
                        {ad, 8'hA5, 6'h0, wd, wr}, q);
                    t0 = cyc;
                    d = 0;
                    do begin
                        ct = bus_ctrl;
                        bus(1'b0, ext_bus_pkg::REG_ACCESS_STATUS, 32'h0, q);
                        if (q[0] === 1'b1) begin
                            `CHK(ct, exp_ctrl(ad[0], wd, wr))
                        end
                        d++;
                    end while (q[0] !== 1'b0 && d < 200);
                    if (d >= 200) begin
                        failures++;
                        results();
                    end
                    tm[k] = cyc - t0;
                end
                // Edge alignment and poll spacing blur each time by a few
                d = tm[3] - tm[0];
                `CHK(d >= 6 && d <= 18, 1'b1)
                d = tm[7] - tm[4];
                `CHK(d >= 6 && d <= 18, 1'b1)
            end
        end
        results();
    end
endmodule // ext_bus_ctrl_test
